// file: common/core_power_params.svh
// constants for the per-core power mode controller
// assumes inclusion by bare name from the package and the design file
`ifndef CORE_POWER_PARAMS_SVH
`define CORE_POWER_PARAMS_SVH
`define MODE_W 3
`define MODE_ON 3'h0
`define MODE_FUNCTIONAL_RETENTION 3'h1
`define MODE_DEEP_RET 3'h2
`define MODE_OFF 3'h3
`define MODE_EMU_OFF 3'h4
`define MODE_DEBUG_RECOVERY 3'h5
`define MODE_WARM_RST 3'h6
`define TIMER_W 8
`define TIMER_ZERO 8'h00
`define TIMER_ONE 8'h01
`define CLEAN_W 4
`define CLEAN_ZERO 4'h0
`define CLEAN_ONE 4'h1
`define CLEAN_L1_CYCLES 4'h4
`define CLEAN_L2_CYCLES 4'h8
`define RESET_CYCLES 4'h2
`define NUM_SHARERS 2
`endif

// file: common/core_power_pkg.sv
// types for the per-core power mode controller
// assumes the params header is on the include path
`include "core_power_params.svh"
package core_power_pkg;
    // mode request from the policy unit
    typedef struct packed {
        logic valid;
        logic [`MODE_W-1:0] mode;
    } mode_req_type;

    // clock-enabling wake sources seen while waiting
    typedef struct packed {
        logic snoop;
        logic maint;
        logic debug_apb;
        logic intc;
        logic utility;
    } wake_src_type;

    // power and reset actions driven to the core
    typedef struct packed {
        logic core_power;
        logic ram_power;
        logic retain_only;
        logic clock_gate;
        logic warm_reset;
        logic full_reset;
        logic coherent;
        logic debug_reachable;
    } power_ctl_type;
endpackage

// file: logic/core_power_mode_controller.sv
// per-core power mode controller: carries out policy unit requests
// assumes request and status inputs come from logic on CORE_CLK
// Overview of operation
// - each core keeps its own mode, independent of other cores
// - vector unit retains only when idle and retention timer expired; the code keeps VEC_RET_REQ set if VEC_IDLE drops with no instruction pending
// - software enables vector retention and sets timer length
// - pending vector instruction brings vector unit out of retention
// - shared vector unit retains only when all sharing cores request
// - deep retention needs timer expired, wait state, no clock enable
// - leave deep retention on wakeup or clock-enabling event
// - deep retention keeps only retention power, executes nothing
// - off mode removes all power and keeps no state
// - going off cleans L1 and L2 and leaves coherency first
// - skip shared L2 clean when the other core stays up
// - debug or utility access while off returns error
// - emulated off does all steps except gating, warm reset only
// - emulated off keeps core power and debug; vector unit and interfaces act as off
// - debug recovery keeps power, warm resets, preserves caches
// - warm reset spares debug, trace, monitor and reliability state
// - core may start on; caches coherent after entering on
// - clock briefly enabled for accesses while still waiting
`include "core_power_params.svh"
module core_power_mode_controller (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire core_power_pkg::mode_req_type MODE_REQ,
    input wire logic START_ON,
    input wire logic IN_WAIT,
    input wire logic WAIT_WAKEUP,
    input wire core_power_pkg::wake_src_type WAKE_SRC,
    input wire logic VEC_RET_ENABLE,
    input wire logic [`TIMER_W-1:0] RET_TIMER_LEN,
    input wire logic VEC_IDLE,
    input wire logic VEC_INSN_PENDING,
    input wire logic PEER_VEC_RET_REQ,
    input wire logic PEER_CORE_UP,
    input wire logic ACCESS_REQ,
    output logic MODE_ACK,
    output logic [`MODE_W-1:0] CUR_MODE,
    output logic VEC_RET_REQ,
    output logic VEC_POWERED,
    output logic TEMP_CLK_EN,
    output core_power_pkg::power_ctl_type POWER_CTL,
    output logic L1_CLEAN,
    output logic L2_CLEAN,
    output logic ACCESS_ERR,
    output logic ACCESS_OK
);
    import core_power_pkg::*;

    typedef enum {
        ST_IDLE,
        ST_CLEAN_L1,
        ST_CLEAN_L2,
        ST_DECOHERE,
        ST_RESET,
        ST_DONE
    } seq_type;

    seq_type seq_q, seq_d;
    logic [`MODE_W-1:0] mode_q, mode_d;
    logic [`MODE_W-1:0] target_q, target_d;
    logic [`CLEAN_W-1:0] cnt_q, cnt_d;
    logic [`TIMER_W-1:0] vtim_q, vtim_d;
    logic [`TIMER_W-1:0] dtim_q, dtim_d;
    logic ack_q, ack_d;
    logic vret_q, vret_d;
    logic tclk_q, tclk_d;
    logic l1_q, l1_d, l2_q, l2_d;
    logic err_q, err_d, ok_q, ok_d;
    logic started_q, started_d;
    power_ctl_type ctl_q, ctl_d;
    logic req_legal;
    logic clk_wake;
    logic deep_ok;

    assign clk_wake = WAKE_SRC.snoop | WAKE_SRC.maint | WAKE_SRC.debug_apb
                    | WAKE_SRC.intc | WAKE_SRC.utility;
    assign req_legal = MODE_REQ.valid
                    && (MODE_REQ.mode <= `MODE_WARM_RST);

    // transition sequencer: cleans, decoherence, reset pulses, ack
    always_comb begin
        seq_d = seq_q;
        mode_d = mode_q;
        target_d = target_q;
        cnt_d = cnt_q;
        ack_d = 1'b0;
        l1_d = 1'b0;
        l2_d = 1'b0;
        started_d = 1'b1;
        // strap sampled once after reset release
        if (!started_q && !START_ON) begin
            mode_d = `MODE_OFF;
        end
        case (seq_q)
            ST_IDLE: begin
                // unsupported codes leave the state untouched
                // deep retention waits for the wait state and expired timer
                if (req_legal && started_q
                    && MODE_REQ.mode != mode_q
                    && (MODE_REQ.mode != `MODE_DEEP_RET
                        || deep_ok)) begin
                    target_d = MODE_REQ.mode;
                    cnt_d = `CLEAN_ZERO;
                    if (MODE_REQ.mode == `MODE_OFF
                        || MODE_REQ.mode == `MODE_EMU_OFF) begin
                        seq_d = ST_CLEAN_L1;
                    end else if (MODE_REQ.mode == `MODE_WARM_RST
                        || MODE_REQ.mode == `MODE_DEBUG_RECOVERY) begin
                        seq_d = ST_RESET; // accepted at once
                    end else begin
                        seq_d = ST_DONE;
                    end
                end
            end
            ST_CLEAN_L1: begin
                l1_d = 1'b1;
                cnt_d = cnt_q + `CLEAN_ONE;
                if (cnt_q == `CLEAN_L1_CYCLES - `CLEAN_ONE) begin
                    cnt_d = `CLEAN_ZERO;
                    // shared L2 stays dirty for the live peer
                    seq_d = PEER_CORE_UP ? ST_DECOHERE : ST_CLEAN_L2;
                end
            end
            ST_CLEAN_L2: begin
                l2_d = 1'b1;
                cnt_d = cnt_q + `CLEAN_ONE;
                if (cnt_q == `CLEAN_L2_CYCLES - `CLEAN_ONE) begin
                    cnt_d = `CLEAN_ZERO;
                    seq_d = ST_DECOHERE;
                end
            end
            ST_DECOHERE: begin
                // emulated off still pulses a warm reset
                seq_d = (target_q == `MODE_EMU_OFF) ? ST_RESET : ST_DONE;
            end
            ST_RESET: begin
                cnt_d = cnt_q + `CLEAN_ONE;
                if (cnt_q == `RESET_CYCLES - `CLEAN_ONE) begin
                    cnt_d = `CLEAN_ZERO;
                    seq_d = ST_DONE;
                end
            end
            ST_DONE: begin
                mode_d = target_q;
                ack_d = 1'b1;
                seq_d = ST_IDLE;
            end
            default: begin
                seq_d = ST_IDLE;
            end
        endcase
        // deep retention exit on any wake, handled without sequencing
        if (seq_q == ST_IDLE && mode_q == `MODE_DEEP_RET
            && (WAIT_WAKEUP || clk_wake)) begin
            mode_d = `MODE_ON;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            seq_q <= ST_IDLE;
            mode_q <= `MODE_ON;
            target_q <= `MODE_ON;
            cnt_q <= `CLEAN_ZERO;
            ack_q <= 1'b0;
            l1_q <= 1'b0;
            l2_q <= 1'b0;
            started_q <= 1'b0;
        end else begin
            seq_q <= seq_d;
            mode_q <= mode_d;
            target_q <= target_d;
            cnt_q <= cnt_d;
            ack_q <= ack_d;
            l1_q <= l1_d;
            l2_q <= l2_d;
            started_q <= started_d;
        end
    end

    // retention timers; restart on any activity
    always_comb begin
        vtim_d = vtim_q;
        dtim_d = dtim_q;
        vret_d = vret_q;
        tclk_d = 1'b0;
        if (!VEC_RET_ENABLE || !VEC_IDLE || VEC_INSN_PENDING) begin
            vtim_d = `TIMER_ZERO;
        end else if (vtim_q != RET_TIMER_LEN) begin
            vtim_d = vtim_q + `TIMER_ONE;
        end
        // local request needs idle, expired timer, software enable
        if (VEC_INSN_PENDING || !VEC_RET_ENABLE) begin
            vret_d = 1'b0;
        end else if (VEC_IDLE && vtim_q == RET_TIMER_LEN) begin
            vret_d = 1'b1;
        end
        if (!IN_WAIT || clk_wake) begin
            dtim_d = `TIMER_ZERO;
        end else if (dtim_q != RET_TIMER_LEN) begin
            dtim_d = dtim_q + `TIMER_ONE;
        end
        // wait state is kept; only the clock opens briefly
        if (IN_WAIT && clk_wake) begin
            tclk_d = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            vtim_q <= `TIMER_ZERO;
            dtim_q <= `TIMER_ZERO;
            vret_q <= 1'b0;
            tclk_q <= 1'b0;
        end else begin
            vtim_q <= vtim_d;
            dtim_q <= dtim_d;
            vret_q <= vret_d;
            tclk_q <= tclk_d;
        end
    end

    // power actions and access answers, decoded from the mode
    logic vec_on_d, vec_on_q;
    assign deep_ok = IN_WAIT && !clk_wake && dtim_q == RET_TIMER_LEN;

    always_comb begin
        ctl_d = '0;
        err_d = 1'b0;
        ok_d = 1'b0;
        vec_on_d = 1'b1;
        ctl_d.warm_reset = (seq_q == ST_RESET);
        case (mode_q)
            `MODE_OFF: begin
                ctl_d.clock_gate = 1'b1;
            end
            `MODE_DEEP_RET: begin
                ctl_d.retain_only = 1'b1;
                ctl_d.ram_power = 1'b1;
                ctl_d.clock_gate = 1'b1;
            end
            `MODE_EMU_OFF: begin
                ctl_d.core_power = 1'b1;
                ctl_d.ram_power = 1'b1;
                ctl_d.debug_reachable = 1'b1;
            end
            default: begin
                ctl_d.core_power = 1'b1;
                ctl_d.ram_power = 1'b1;
                ctl_d.coherent = (seq_q == ST_IDLE);
                ctl_d.debug_reachable = 1'b1;
            end
        endcase
        if (mode_q == `MODE_OFF || mode_q == `MODE_EMU_OFF
            || mode_q == `MODE_DEEP_RET) begin
            vec_on_d = 1'b0;
        end else if (mode_q == `MODE_FUNCTIONAL_RETENTION && vret_q
            && PEER_VEC_RET_REQ && !VEC_INSN_PENDING) begin
            vec_on_d = 1'b0;
        end
        if (ACCESS_REQ) begin
            if (mode_q == `MODE_OFF || mode_q == `MODE_EMU_OFF) begin
                err_d = 1'b1;
            end else begin
                ok_d = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctl_q <= '0;
            err_q <= 1'b0;
            ok_q <= 1'b0;
            vec_on_q <= 1'b1;
        end else begin
            ctl_q <= ctl_d;
            err_q <= err_d;
            ok_q <= ok_d;
            vec_on_q <= vec_on_d;
        end
    end

    assign MODE_ACK = ack_q;
    assign CUR_MODE = mode_q;
    assign VEC_RET_REQ = vret_q;
    assign VEC_POWERED = vec_on_q;
    assign TEMP_CLK_EN = tclk_q;
    assign POWER_CTL = ctl_q;
    assign L1_CLEAN = l1_q;
    assign L2_CLEAN = l2_q;
    assign ACCESS_ERR = err_q;
    assign ACCESS_OK = ok_q;

    // deep retention grant is gated by the wait state, no clock enable and expired wait timer
    property p_deep_needs_wait;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (seq_q == ST_IDLE && MODE_REQ.valid && mode_q != `MODE_DEEP_RET
         && MODE_REQ.mode == `MODE_DEEP_RET && !deep_ok)
        |=> seq_q == ST_IDLE;
    endproperty
    a_deep_needs_wait: assert property (p_deep_needs_wait)
        else $error("deep retention taken before conditions met");

    sequence s_clean_l1;
        L1_CLEAN [*4];
    endsequence

    property p_off_cleans;
        @(posedge CORE_CLK) disable iff (!RESETN)
        $rose(seq_q == ST_CLEAN_L1) |=> s_clean_l1;
    endproperty
    a_off_cleans: assert property (p_off_cleans)
        else $error("off entry did not clean l1 for four cycles");

    property p_peer_skip_l2;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (seq_q == ST_CLEAN_L1 && PEER_CORE_UP
         && cnt_q == `CLEAN_L1_CYCLES - `CLEAN_ONE) |=> !L2_CLEAN [*3];
    endproperty
    a_peer_skip_l2: assert property (p_peer_skip_l2)
        else $error("l2 cleaned while peer core up");

    property p_off_err;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (ACCESS_REQ && mode_q == `MODE_OFF) |=> ACCESS_ERR && !ACCESS_OK;
    endproperty
    a_off_err: assert property (p_off_err)
        else $error("access while off not answered with error");

    property p_bad_req;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (seq_q == ST_IDLE && MODE_REQ.valid
         && MODE_REQ.mode > `MODE_WARM_RST && mode_q != `MODE_DEEP_RET)
        |=> $stable(CUR_MODE) && seq_q == ST_IDLE;
    endproperty
    a_bad_req: assert property (p_bad_req)
        else $error("unsupported request changed mode");

    property p_ack_mode;
        @(posedge CORE_CLK) disable iff (!RESETN)
        $rose(MODE_ACK) |-> CUR_MODE == $past(target_q);
    endproperty
    a_ack_mode: assert property (p_ack_mode)
        else $error("ack without reaching target mode");

    property p_vec_pending;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (VEC_INSN_PENDING && mode_q == `MODE_FUNCTIONAL_RETENTION) |=> VEC_POWERED;
    endproperty
    a_vec_pending: assert property (p_vec_pending)
        else $error("vector unit off with instruction pending");

    property p_vec_share;
        @(posedge CORE_CLK) disable iff (!RESETN)
        !PEER_VEC_RET_REQ && mode_q == `MODE_FUNCTIONAL_RETENTION |=> VEC_POWERED;
    endproperty
    a_vec_share: assert property (p_vec_share)
        else $error("shared vector unit retained without peer");

    property p_deep_wake;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (mode_q == `MODE_DEEP_RET && seq_q == ST_IDLE && clk_wake)
        |=> CUR_MODE == `MODE_ON;
    endproperty
    a_deep_wake: assert property (p_deep_wake)
        else $error("deep retention not left on wake");

    property p_temp_clk;
        @(posedge CORE_CLK) disable iff (!RESETN)
        (IN_WAIT && WAKE_SRC.snoop) |=> TEMP_CLK_EN;
    endproperty
    a_temp_clk: assert property (p_temp_clk)
        else $error("clock not opened for snoop in wait");
endmodule // core_power_mode_controller

// file: tb/policy_unit_model.sv
// policy unit model: presents one mode request and holds it until acked
// assumes the bench raises want with a code and drops it after the ack
`include "core_power_params.svh"
module policy_unit_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic want,
    input wire logic [`MODE_W-1:0] want_mode,
    input wire logic mode_ack,
    output core_power_pkg::mode_req_type mode_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import core_power_pkg::*;
    logic valid_q;
    logic [`MODE_W-1:0] mode_q;
    // request stays up until acked; dropping want abandons it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            valid_q <= 1'b0;
            mode_q <= 3'h0;
        end else if (valid_q && (mode_ack || !want)) begin
            valid_q <= 1'b0;
        end else if (!valid_q && want) begin
            valid_q <= 1'b1;
            mode_q <= want_mode;
        end
    end
    // idle code lines flip so a stale code never looks valid
    assign mode_req.valid = valid_q;
    assign mode_req.mode = valid_q ? mode_q : ~mode_q;
endmodule // policy_unit_model

// file: tb/test_core_power_mode_controller.sv
// bench for the core power mode controller driven by a policy unit model
// assumes a 250 MHz clock and the controller's hand-over timing
`include "core_power_params.svh"
module test_core_power_mode_controller;
    timeunit 1ns;
    timeprecision 1ps;
    import core_power_pkg::*;
    logic clk;
    logic rstn;
    logic start_on;
    logic in_wait;
    logic wait_wakeup;
    wake_src_type wake;
    logic vec_en;
    logic [`TIMER_W-1:0] tmr_len;
    logic vec_idle;
    logic vec_pend;
    logic peer_vec;
    logic peer_up;
    logic acc_req;
    logic want;
    logic [`MODE_W-1:0] want_mode;
    mode_req_type req;
    logic ack;
    logic [`MODE_W-1:0] cur_mode;
    logic vec_ret_req;
    logic vec_pwr;
    logic temp_clk;
    power_ctl_type pctl;
    logic l1c;
    logic l2c;
    logic acc_err;
    logic acc_ok;
    logic [3:0] saw; // l1 clean, l2 clean, warm reset, full reset
    int err_count;
    int cmp_count;

    core_power_mode_controller core_power_mode_controller_inst (
        .CORE_CLK(clk), .RESETN(rstn), .MODE_REQ(req),
        .START_ON(start_on), .IN_WAIT(in_wait),
        .WAIT_WAKEUP(wait_wakeup), .WAKE_SRC(wake),
        .VEC_RET_ENABLE(vec_en), .RET_TIMER_LEN(tmr_len),
        .VEC_IDLE(vec_idle), .VEC_INSN_PENDING(vec_pend),
        .PEER_VEC_RET_REQ(peer_vec), .PEER_CORE_UP(peer_up),
        .ACCESS_REQ(acc_req), .MODE_ACK(ack), .CUR_MODE(cur_mode),
        .VEC_RET_REQ(vec_ret_req), .VEC_POWERED(vec_pwr),
        .TEMP_CLK_EN(temp_clk), .POWER_CTL(pctl), .L1_CLEAN(l1c),
        .L2_CLEAN(l2c), .ACCESS_ERR(acc_err), .ACCESS_OK(acc_ok)
    );
    policy_unit_model policy_unit_model_inst (
        .clk(clk), .resetn(rstn), .want(want), .want_mode(want_mode),
        .mode_ack(ack), .mode_req(req)
    );

    // 4 ns period
    always #2 clk = ~clk;

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    // one clock, inputs move 1 ns later; a spent bound ends the run
    task automatic step(inout int n, input int lim);
        @(posedge clk);
        #1;
        n++;
        saw |= {l1c, l2c, pctl.warm_reset, pctl.full_reset};
        if (n > lim) begin
            check(1'b0, "wait ran out");
            print_verdict();
        end
    endtask

    task automatic do_mode(input logic [`MODE_W-1:0] m, input int lat);
        int n;
        n = 0;
        want_mode = m;
        want = 1'b1;
        while (req.valid !== 1'b1) step(n, 4);
        n = 0;
        saw = 4'h0;
        while (ack !== 1'b1) step(n, 40);
        want = 1'b0;
        check(n == lat, "ack latency");
        check(cur_mode === m, "mode after ack");
        step(n, 99);
        step(n, 99);
    endtask

    task automatic access(input logic exp_err);
        int n;
        n = 0;
        acc_req = 1'b1;
        step(n, 9);
        acc_req = 1'b0;
        check(acc_err === exp_err, "access error flag");
        check(acc_ok === !exp_err, "access ok flag");
    endtask

    task automatic sc_reset();
        check(cur_mode === `MODE_ON, "start mode");
        check(vec_pwr === 1'b1, "vector unpowered");
        check(ack === 1'b0, "stray ack");
    endtask

    // code 7 is held for a while and must change nothing
    task automatic sc_bad();
        int n;
        n = 0;
        want_mode = 3'h7;
        want = 1'b1;
        repeat (20) begin
            step(n, 99);
            check(ack === 1'b0, "odd code acked");
        end
        check(cur_mode === `MODE_ON, "odd code moved");
        want = 1'b0;
        step(n, 99);
        step(n, 99);
    endtask

    task automatic sc_warm();
        do_mode(`MODE_WARM_RST, 4);
        check(saw[1] && !saw[0], "warm reset kind");
        do_mode(`MODE_ON, 2);
        do_mode(`MODE_DEBUG_RECOVERY, 4);
        check(saw[1] && !saw[0], "recovery reset kind");
        check(pctl.ram_power === 1'b1, "recovery ram");
        do_mode(`MODE_ON, 2);
        check(!saw[3] && !saw[2], "caches touched");
    endtask

    task automatic sc_off(input logic peer);
        peer_up = peer;
        do_mode(`MODE_OFF, peer ? 7 : 15);
        check(saw[3] === 1'b1, "no l1 clean");
        check(saw[2] === !peer, "l2 clean choice");
        check(pctl.clock_gate === 1'b1, "off ungated");
        check(pctl.core_power === 1'b0, "off powered");
        access(1'b1);
        do_mode(`MODE_ON, 2);
        check(pctl.coherent === 1'b1, "not coherent");
        access(1'b0);
        peer_up = 1'b1;
    endtask

    task automatic sc_emu();
        do_mode(`MODE_EMU_OFF, 9);
        check(saw[1] && !saw[0], "emu reset kind");
        check(pctl.clock_gate === 1'b0, "emu gated");
        check(pctl.core_power === 1'b1, "emu unpowered");
        check(pctl.debug_reachable === 1'b1, "emu debug");
        access(1'b1);
        do_mode(`MODE_ON, 2);
    endtask

    task automatic sc_vec();
        int n;
        do_mode(`MODE_FUNCTIONAL_RETENTION, 2);
        vec_idle = 1'b1;
        vec_en = 1'b1;
        n = 0;
        repeat (3) step(n, 99);
        check(vec_ret_req === 1'b0, "timer too short");
        while (vec_ret_req !== 1'b1) step(n, 12);
        repeat (4) step(n, 99);
        check(vec_pwr === 1'b1, "off without peer");
        peer_vec = 1'b1;
        n = 0;
        while (vec_pwr !== 1'b0) step(n, 4);
        vec_pend = 1'b1;
        vec_idle = 1'b0;
        n = 0;
        while (vec_pwr !== 1'b1) step(n, 4);
        vec_en = 1'b0;
        vec_pend = 1'b0;
        vec_idle = 1'b1;
        repeat (10) step(n, 99);
        check(vec_pwr === 1'b1, "off while disabled");
        peer_vec = 1'b0;
        do_mode(`MODE_ON, 2);
    endtask

    task automatic sc_deep();
        int n;
        in_wait = 1'b1;
        // entry held off until the wait timer has run its length
        do_mode(`MODE_DEEP_RET, 5);
        check(pctl.retain_only === 1'b1, "not retaining");
        wake.snoop = 1'b1;
        n = 0;
        while (cur_mode !== `MODE_ON) step(n, 6);
        wake = '0;
        do_mode(`MODE_DEEP_RET, 5);
        wait_wakeup = 1'b1;
        n = 0;
        while (cur_mode !== `MODE_ON) step(n, 6);
        wait_wakeup = 1'b0;
        wake.intc = 1'b1;
        step(n, 99);
        check(temp_clk === 1'b1, "no temp clock");
        check(cur_mode === `MODE_ON, "left on");
        wake = '0;
        in_wait = 1'b0;
    endtask

    // reset for 4 cycles, then the scenarios in turn
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        start_on = 1'b1;
        in_wait = 1'b0;
        wait_wakeup = 1'b0;
        wake = '0;
        vec_en = 1'b0;
        tmr_len = 8'h04;
        vec_idle = 1'b0;
        vec_pend = 1'b0;
        peer_vec = 1'b0;
        peer_up = 1'b1;
        acc_req = 1'b0;
        want = 1'b0;
        want_mode = 3'h0;
        saw = 4'h0;
        err_count = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        sc_reset();
        sc_bad();
        sc_warm();
        sc_off(1'b1);
        sc_off(1'b0);
        sc_emu();
        sc_vec();
        sc_deep();
        print_verdict();
    end
endmodule // test_core_power_mode_controller
